// >>> rtl/tlbd_consts.vh
// Function
// - line loop returns network rx, dte still fed
// - line loop in master timing uses network timing
// - payload loop inside framer, dte cut off
// - dte gets local all-ones during payload loop
// - aggregate loop returns dte tx, network still fed
// - aggregate loop in network timing uses master
// - network loops set status and network indicator
// - remote csu loop sends loop-up request
// - remote dsu loop sends loop-up request
// - local bidirectional loop at dte port
// - dte loops set status and dte indicator
// - remote standard loop uses standard loop-up code
// - remote vendor loop uses proprietary loop-up code
// - bit test sends 511 or quasi-random pattern
// - pattern in all slots or dte slots only
// - bit test keeps network rx to dte
// - bit test lights network indicator, status on
// - bit test reports sync, errors, seconds, rate
// - error insert flips one bit; reset restarts
`ifndef TLBD_CONSTS_VH
`define TLBD_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define TLBD_ADDR_CTRL    12'h000
`define TLBD_ADDR_STATUS  12'h004
`define TLBD_ADDR_ERRCNT  12'h008
`define TLBD_ADDR_SECS    12'h00C
`define TLBD_ADDR_BER     12'h010
`define TLBD_ADDR_SLOTS   12'h014

// ****************************************
// control field positions
// ****************************************
`define TLBD_CTRL_MODE_LSB  0
`define TLBD_CTRL_MODE_MSB  3
`define TLBD_CTRL_QRSS      4
`define TLBD_CTRL_DTEBW     5
`define TLBD_CTRL_MASTER    6
`define TLBD_CTRL_ERRINS    8
`define TLBD_CTRL_BRESET    9

// ****************************************
// mode codes
// ****************************************
`define TLBD_MODE_NONE     4'h0
`define TLBD_MODE_LINE     4'h1
`define TLBD_MODE_PAYLOAD  4'h2
`define TLBD_MODE_AGGR     4'h3
`define TLBD_MODE_RCSU     4'h4
`define TLBD_MODE_RDSU     4'h5
`define TLBD_MODE_BIDIR    4'h6
`define TLBD_MODE_RSTD     4'h7
`define TLBD_MODE_RVEND    4'h8
`define TLBD_MODE_BERT     4'h9

// ****************************************
// loop-up request codes
// ****************************************
`define TLBD_REQ_NONE   3'h0
`define TLBD_REQ_CSU    3'h1
`define TLBD_REQ_DSU    3'h2
`define TLBD_REQ_STD    3'h3
`define TLBD_REQ_VEND   3'h4

// ****************************************
// timing and frame
// ****************************************
`define TLBD_CLK_HZ        25000000
`define TLBD_SLOTS         24
`define TLBD_BITS_PER_SLOT 8
`define TLBD_SYNC_BITS     9
`define TLBD_LOSS_ERRS     16

`endif

// >>> rtl/tlbd_diag.v
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_consts.vh"

module tlbd_diag #(
  parameter SEC_CYCLES = `TLBD_CLK_HZ
) (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // network side bit stream
  input  wire        net_rx_bit,
  input  wire        net_bit_stb,
  output reg         net_tx_bit,
  // dte side bit stream
  input  wire        dte_tx_bit,
  output reg         dte_rx_bit,
  // front-end loop controls
  output reg         fe_line_loop,
  output reg         fe_aggr_loop,
  // timing and indicators
  output reg         use_master_timing,
  output reg         network_side_test_indicator,
  output reg         terminal_side_test_indicator,
  output reg  [2:0]  loop_up_req
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] s_rx;
  reg [1:0] s_dte;
  reg [1:0] s_stb;
  reg       stb_d;
  wire      rx   = s_rx[1];
  wire      dtx  = s_dte[1];
  wire      bstb = s_stb[1] & ~stb_d;

  always @(posedge core_clk) begin
    if (!rstn) begin
      s_rx  <= 2'h0;
      s_dte <= 2'h0;
      s_stb <= 2'h0;
      stb_d <= 1'b0;
    end else if (clk_en) begin
      s_rx  <= {s_rx[0], net_rx_bit};
      s_dte <= {s_dte[0], dte_tx_bit};
      s_stb <= {s_stb[0], net_bit_stb};
      stb_d <= s_stb[1];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [3:0]  mode;
  reg        qrss;
  reg        dte_bw;
  reg        cfg_master;
  reg [23:0] dte_slots;
  reg        err_req;
  reg        gen_rst;
  reg [31:0] err_cnt;
  reg [31:0] secs;
  reg [31:0] bits_cnt;
  reg        in_sync;
  wire       bert_on = (mode == `TLBD_MODE_BERT);
  wire       apb_wr  = psel & penable & pwrite & pready;
  wire       apb_rd  = psel & ~penable & ~pwrite;
  wire       addr_ok = (paddr == `TLBD_ADDR_CTRL) |
                       (paddr == `TLBD_ADDR_STATUS) |
                       (paddr == `TLBD_ADDR_ERRCNT) |
                       (paddr == `TLBD_ADDR_SECS) |
                       (paddr == `TLBD_ADDR_BER) |
                       (paddr == `TLBD_ADDR_SLOTS);
  reg [31:0] rd_mux;
  reg        err_done;

  always @* begin
    case (paddr)
      `TLBD_ADDR_CTRL:   rd_mux = {22'h000000, gen_rst, err_req, 1'b0,
                                   cfg_master, dte_bw, qrss, mode};
      `TLBD_ADDR_STATUS: rd_mux = {28'h0000000, in_sync, bert_on,
                                   terminal_side_test_indicator,
                                   network_side_test_indicator};
      `TLBD_ADDR_ERRCNT: rd_mux = err_cnt;
      `TLBD_ADDR_SECS:   rd_mux = secs;
      `TLBD_ADDR_BER:    rd_mux = bits_cnt;
      `TLBD_ADDR_SLOTS:  rd_mux = {8'h00, dte_slots};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // no wait state: setup cycle latches read data, first access cycle answers
  always @(posedge core_clk) begin
    if (!rstn) begin
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      mode       <= `TLBD_MODE_NONE;
      qrss       <= 1'b0;
      dte_bw     <= 1'b0;
      cfg_master <= 1'b0;
      dte_slots  <= 24'h000000;
      err_req    <= 1'b0;
      gen_rst    <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (apb_rd)
        prdata <= rd_mux;
      if (err_done)
        err_req <= 1'b0;
      gen_rst <= 1'b0;
      if (apb_wr && paddr == `TLBD_ADDR_CTRL) begin
        mode       <= pwdata[`TLBD_CTRL_MODE_MSB:`TLBD_CTRL_MODE_LSB];
        qrss       <= pwdata[`TLBD_CTRL_QRSS];
        dte_bw     <= pwdata[`TLBD_CTRL_DTEBW];
        cfg_master <= pwdata[`TLBD_CTRL_MASTER];
        if (pwdata[`TLBD_CTRL_ERRINS])
          err_req <= 1'b1;
        gen_rst <= pwdata[`TLBD_CTRL_BRESET];
      end
      if (apb_wr && paddr == `TLBD_ADDR_SLOTS)
        dte_slots <= pwdata[23:0];
    end
  end

  // ****************************************
  // frame position
  // ****************************************
  reg [2:0] bit_pos;
  reg [4:0] slot;
  reg       rx_hit;
  wire slot_hit = ~dte_bw | dte_slots[slot];

  always @(posedge core_clk) begin
    if (!rstn) begin
      bit_pos <= 3'h0;
      slot    <= 5'h00;
      rx_hit  <= 1'b0;
    end else if (clk_en && bstb) begin
      bit_pos <= bit_pos + 3'h1;
      rx_hit  <= slot_hit;
      if (bit_pos == 3'h7)
        slot <= (slot == 5'd23) ? 5'h00 : slot + 5'h01;
    end
  end

  // ****************************************
  // pattern generator and checker
  // ****************************************
  reg  [19:0] gen;
  reg  [19:0] chk;
  reg  [3:0]  good_run;
  reg  [4:0]  bad_run;
  reg  [4:0]  fill;
  wire gen_fb  = qrss ? (gen[19] ^ gen[16]) : (gen[8] ^ gen[4]);
  wire chk_fb  = qrss ? (chk[19] ^ chk[16]) : (chk[8] ^ chk[4]);
  wire gen_bit = gen_fb ^ err_req;
  wire bad     = rx ^ chk_fb;
  // stale stages from an earlier run must not fake a sync
  wire loaded  = qrss ? (fill == 5'h14) : (fill >= 5'h09);
  wire tick    = clk_en & bstb & bert_on & slot_hit;
  // looped bits come back one bit time late, so receive uses the
  // previous bit's slot; a longer line delay would need a framer
  wire rtick   = clk_en & bstb & bert_on & rx_hit;

  always @(posedge core_clk) begin
    if (!rstn) begin
      gen      <= 20'hFFFFF;
      chk      <= 20'h00000;
      good_run <= 4'h0;
      bad_run  <= 5'h00;
      fill     <= 5'h00;
      in_sync  <= 1'b0;
      err_cnt  <= 32'h00000000;
      bits_cnt <= 32'h00000000;
      err_done <= 1'b0;
    end else if (clk_en) begin
      err_done <= 1'b0;
      if (gen_rst || !bert_on) begin
        gen      <= 20'hFFFFF;
        in_sync  <= 1'b0;
        good_run <= 4'h0;
        bad_run  <= 5'h00;
        fill     <= 5'h00;
        err_cnt  <= 32'h00000000;
        bits_cnt <= 32'h00000000;
      end else begin
        if (tick) begin
          gen      <= {gen[18:0], gen_fb};
          err_done <= err_req;
        end
        if (rtick) begin
          chk <= {chk[18:0], in_sync ? chk_fb : rx};
          if (!in_sync) begin
            if (fill != 5'h14)
              fill <= fill + 5'h01;
            good_run <= (bad || !loaded) ? 4'h0 : good_run + 4'h1;
            if (loaded && !bad && good_run == `TLBD_SYNC_BITS - 1)
              in_sync <= 1'b1;
          end else begin
            bits_cnt <= bits_cnt + 32'h1;
            if (bad) begin
              err_cnt <= err_cnt + 32'h1;
              bad_run <= bad_run + 5'h01;
              if (bad_run == `TLBD_LOSS_ERRS - 1) begin
                in_sync  <= 1'b0;
                good_run <= 4'h0;
                bad_run  <= 5'h00;
                fill     <= 5'h00;
              end
            end else
              bad_run <= 5'h00;
          end
        end
      end
    end
  end

  // ****************************************
  // elapsed seconds
  // ****************************************
  reg [31:0] sec_div;
  always @(posedge core_clk) begin
    if (!rstn) begin
      sec_div <= 32'h00000000;
      secs    <= 32'h00000000;
    end else if (clk_en) begin
      if (gen_rst || !bert_on) begin
        sec_div <= 32'h00000000;
        secs    <= 32'h00000000;
      end else if (sec_div == SEC_CYCLES - 1) begin
        sec_div <= 32'h00000000;
        secs <= secs + 32'h1;
      end else
        sec_div <= sec_div + 32'h1;
    end
  end

  // ****************************************
  // path control
  // ****************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      net_tx_bit                   <= 1'b1;
      dte_rx_bit                   <= 1'b1;
      fe_line_loop                 <= 1'b0;
      fe_aggr_loop                 <= 1'b0;
      use_master_timing            <= 1'b0;
      network_side_test_indicator  <= 1'b0;
      terminal_side_test_indicator <= 1'b0;
      loop_up_req                  <= `TLBD_REQ_NONE;
    end else if (clk_en) begin
      net_tx_bit        <= dtx;
      dte_rx_bit        <= rx;
      fe_line_loop      <= 1'b0;
      fe_aggr_loop      <= 1'b0;
      use_master_timing <= cfg_master;
      loop_up_req       <= `TLBD_REQ_NONE;
      network_side_test_indicator <= (mode >= `TLBD_MODE_LINE &&
                                      mode <= `TLBD_MODE_RDSU) | bert_on;
      terminal_side_test_indicator <= (mode >= `TLBD_MODE_BIDIR &&
                                       mode <= `TLBD_MODE_RVEND);
      case (mode)
        `TLBD_MODE_LINE: begin
          fe_line_loop      <= 1'b1;
          net_tx_bit        <= rx;
          use_master_timing <= 1'b0;
        end
        `TLBD_MODE_PAYLOAD: begin
          net_tx_bit <= rx;
          dte_rx_bit <= 1'b1;
        end
        `TLBD_MODE_AGGR: begin
          fe_aggr_loop      <= 1'b1;
          dte_rx_bit        <= dtx;
          use_master_timing <= 1'b1;
        end
        `TLBD_MODE_RCSU:  loop_up_req <= `TLBD_REQ_CSU;
        `TLBD_MODE_RDSU:  loop_up_req <= `TLBD_REQ_DSU;
        `TLBD_MODE_BIDIR: begin
          net_tx_bit <= rx;
          dte_rx_bit <= dtx;
        end
        `TLBD_MODE_RSTD:  loop_up_req <= `TLBD_REQ_STD;
        `TLBD_MODE_RVEND: loop_up_req <= `TLBD_REQ_VEND;
        `TLBD_MODE_BERT: begin
          net_tx_bit <= slot_hit ? gen_bit : dtx;
          dte_rx_bit <= rx;
        end
        default: begin
          net_tx_bit <= dtx;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> testbench/tlbd_diag_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_consts.vh"
// ****************************************
// port checker
// ****************************************
module tlbd_diag_chk (
  // clock, reset, enable
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // observed outputs
  input wire logic        net_tx_bit,
  input wire logic        dte_rx_bit,
  input wire logic        fe_line_loop,
  input wire logic        fe_aggr_loop,
  input wire logic        use_master_timing,
  input wire logic        network_side_test_indicator,
  input wire logic        terminal_side_test_indicator,
  input wire logic [2:0]  loop_up_req,
  // line and dte pins
  input wire logic        net_rx_bit,
  input wire logic        dte_tx_bit
);
  logic [3:0] mode_q;
  logic       mst_q;
  logic [2:0] age;
  wire        w_ctrl;
  assign w_ctrl = psel && penable && pwrite && pready && clk_en
                  && paddr == `TLBD_ADDR_CTRL;
  // age saturates so outputs stay checked in long runs
  always @(posedge core_clk) begin
    if (!rstn) begin
      mode_q <= 4'h0;
      mst_q <= 1'b0;
      age <= 3'h7;
    end else if (w_ctrl) begin
      mode_q <= pwdata[3:0];
      mst_q <= pwdata[6];
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_line_loop: assert property (age >= 3'h2 |-> fe_line_loop == (mode_q == 4'h1))
    else $error("line loop control wrong");
  a_aggr_loop: assert property (age >= 3'h2 |-> fe_aggr_loop == (mode_q == 4'h3))
    else $error("aggregate loop control wrong");
  a_net_ind: assert property (age >= 3'h2 |-> network_side_test_indicator ==
    ((mode_q >= 4'h1 && mode_q <= 4'h5) || mode_q == 4'h9))
    else $error("network indicator wrong");
  a_dte_ind: assert property (age >= 3'h2 |-> terminal_side_test_indicator ==
    (mode_q >= 4'h6 && mode_q <= 4'h8))
    else $error("dte indicator wrong");
  a_timing_src: assert property (age >= 3'h2 |-> use_master_timing ==
    (mode_q == 4'h3 || (mst_q && mode_q != 4'h1)))
    else $error("timing source wrong");
  a_loopup_code: assert property (age >= 3'h2 |-> loop_up_req ==
    (mode_q == 4'h4 ? 3'h1 : mode_q == 4'h5 ? 3'h2 : mode_q == 4'h7 ? 3'h3 :
     mode_q == 4'h8 ? 3'h4 : 3'h0))
    else $error("loop-up code wrong");
  a_payload_ones: assert property (
    age >= 3'h2 && mode_q == 4'h2 |-> dte_rx_bit)
    else $error("dte not fed ones");
  a_net_loop: assert property (
    age >= 3'h2 && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3) &&
    (mode_q == 4'h1 || mode_q == 4'h2 || mode_q == 4'h6) |->
    net_tx_bit == $past(net_rx_bit, 3))
    else $error("network loop path wrong");
  a_dte_loop: assert property (
    age >= 3'h2 && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3) &&
    (mode_q == 4'h3 || mode_q == 4'h6) |->
    dte_rx_bit == $past(dte_tx_bit, 3))
    else $error("dte loop path wrong");
  a_bert_rx: assert property (
    age >= 3'h2 && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3) &&
    mode_q == 4'h9 |-> dte_rx_bit == $past(net_rx_bit, 3))
    else $error("receive path lost in bit test");
  a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  a_err_ready: assert property (pslverr |-> pready && $past(psel))
    else $error("error without ready");
endmodule
bind tlbd_diag tlbd_diag_chk tlbd_diag_chk_i (.core_clk, .rstn, .clk_en,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .dte_rx_bit,
  .fe_line_loop, .fe_aggr_loop, .use_master_timing,
  .network_side_test_indicator, .terminal_side_test_indicator, .loop_up_req,
  .net_tx_bit, .net_rx_bit, .dte_tx_bit);
`default_nettype wire

// >>> testbench/tlbd_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far end: t1 line and dte equipment
// ****************************************
module tlbd_far_end (
  // clock
  input  wire logic       core_clk,
  // loop controls
  input  wire logic       far_loop,
  input  wire logic [2:0] loop_up_req,
  // line and dte bits
  input  wire logic       net_tx_bit,
  output var  logic       net_rx_bit,
  output var  logic       net_bit_stb,
  output var  logic       dte_tx_bit
);
  logic [2:0] div = 3'h0;
  initial begin
    net_rx_bit = 1'b0;
    net_bit_stb = 1'b0;
    dte_tx_bit = 1'b0;
  end
  // line bit clock runs free; strobe rises once every 8 cycles
  always @(posedge core_clk) begin
    div <= div + 3'h1;
    net_bit_stb <= div[2];
    if (div == 3'h7) begin
      dte_tx_bit <= ~dte_tx_bit;
      if (far_loop || loop_up_req != 3'h0)
        net_rx_bit <= net_tx_bit;
      else
        net_rx_bit <= ~net_rx_bit;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_consts.vh"
module tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        far_loop = 1'b0;
  logic        clk_en = 1'b1;
  logic [31:0] prdata, q, s1;
  logic        pready, pslverr, e, net_rx_bit, net_bit_stb, net_tx_bit;
  logic        dte_tx_bit, dte_rx_bit, fe_line_loop, fe_aggr_loop;
  logic        use_master_timing, network_side_test_indicator;
  logic        terminal_side_test_indicator;
  logic [2:0]  loop_up_req;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          m;
  always #20 core_clk = ~core_clk;
  tlbd_diag #(.SEC_CYCLES(50)) tlbd_diag_i (.core_clk, .rstn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .net_rx_bit, .net_bit_stb, .net_tx_bit, .dte_tx_bit, .dte_rx_bit,
    .fe_line_loop, .fe_aggr_loop, .use_master_timing,
    .network_side_test_indicator, .terminal_side_test_indicator,
    .loop_up_req);
  tlbd_far_end tlbd_far_end_i (.core_clk, .far_loop, .loop_up_req,
    .net_tx_bit, .net_rx_bit, .net_bit_stb, .dte_tx_bit);
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge follows so calls never collide
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50)
      num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdchk(`TLBD_ADDR_STATUS, 32'h0);
    for (m = 0; m < 12; m++) begin
      apb(1'b1, `TLBD_ADDR_CTRL, m | (m[0] ? 32'h40 : 32'h0));
      repeat (12) @(posedge core_clk);
      rdchk(`TLBD_ADDR_STATUS, {29'h0, m == 9, m >= 6 && m <= 8,
        (m >= 1 && m <= 5) || m == 9});
    end
    far_loop <= 1'b1;
    apb(1'b1, `TLBD_ADDR_SLOTS, 32'h00A5000F);
    rdchk(`TLBD_ADDR_SLOTS, 32'h00A5000F);
    for (m = 0; m < 3; m++) begin
      apb(1'b1, `TLBD_ADDR_CTRL, 32'h0);
      apb(1'b1, `TLBD_ADDR_CTRL, 32'h9 | (m << 4));
      // dte-only slots may need most of a frame to reach sync
      repeat (m == 2 ? 2000 : 800) @(posedge core_clk);
      rdchk(`TLBD_ADDR_STATUS, 32'hD);
      rdchk(`TLBD_ADDR_ERRCNT, 32'h0);
      apb(1'b0, `TLBD_ADDR_SECS, 32'h0);
      chk(q != 0, 1);
      apb(1'b1, `TLBD_ADDR_CTRL, 32'h109 | (m << 4));
      repeat (m == 2 ? 2000 : 800) @(posedge core_clk);
      rdchk(`TLBD_ADDR_ERRCNT, 32'h1);
      apb(1'b1, `TLBD_ADDR_CTRL, 32'h209 | (m << 4));
      rdchk(`TLBD_ADDR_STATUS, 32'h5);
      rdchk(`TLBD_ADDR_ERRCNT, 32'h0);
    end
    apb(1'b1, `TLBD_ADDR_CTRL, 32'h9);
    repeat (100) @(posedge core_clk);
    apb(1'b0, `TLBD_ADDR_SECS, 32'h0);
    s1 = q;
    clk_en <= 1'b0;
    repeat (200) @(posedge core_clk);
    clk_en <= 1'b1;
    apb(1'b0, `TLBD_ADDR_SECS, 32'h0);
    chk(q - s1 < 2, 1);
    apb(1'b1, `TLBD_ADDR_CTRL, 32'h0);
    rdchk(`TLBD_ADDR_ERRCNT, 32'h0);
    rdchk(12'h020, 32'h0);
    chk(e, 1'b1);
    give_verdict;
  end
endmodule
`default_nettype wire
